// File: common/pstage_pkg.sv
// Purpose: Shared constants and types for the power stage protection block.
// Assumes: A 20 MHz system clock; times are converted to cycles here.
// Notes:   Register offsets and field positions live here so the bench sees one map.
package pstage_pkg;

    // System clock in kHz keeps the cycle arithmetic in 32 bits.
    localparam int unsigned CLK_KHZ = 20_000;

    // Times as printed, in ns.
    localparam int unsigned NEG_LIMIT_NS   = 40;
    localparam int unsigned TRI_WINDOW_NS  = 50;
    localparam int unsigned STANDBY_NS     = 2_000;
    localparam int unsigned CS_WAKE_NS     = 20_000;

    // A least time rounds up; a forced-off time of 40 ns also rounds up so it is never shorter.
    localparam int unsigned NEG_LIMIT_CYC  = (NEG_LIMIT_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int unsigned TRI_WINDOW_CYC = (TRI_WINDOW_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int unsigned STANDBY_CYC    = (STANDBY_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int unsigned CS_WAKE_CYC    = (CS_WAKE_NS * CLK_KHZ + 999_999) / 1_000_000;

    // Consecutive high-side over-current cycles that trip the latch.
    localparam int unsigned OC_TRIP_COUNT  = 4;

    // Register map, byte addresses on a 32-bit Avalon-MM word bus.
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] FAULT_OFS  = 4'h8;
    localparam logic [3:0] IDENT_OFS  = 4'hC;

    // Control fields.
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET_VAL  = 32'h0000_0001;

    // Identity word; the value is arbitrary.
    localparam logic [31:0] IDENT_VAL = 32'h5A17_0001;

    // Fault cause bits in the fault register.
    localparam int unsigned FLT_OC_BIT    = 0;
    localparam int unsigned FLT_OT_BIT    = 1;
    localparam int unsigned FLT_SHORT_BIT = 2;

    // Tri-level pin decode.
    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_HIGH = 2'b01,
        LVL_MID  = 2'b10
    } level_t;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_DRAIN    = 3'b001,
        ST_OFF      = 3'b010,
        ST_STANDBY  = 3'b011
    } stage_state_t;

endpackage : pstage_pkg

// File: logic/bus_regs.sv
// Purpose: Avalon-MM slave holding the control word and showing block state.
// Assumes: 32-bit data, byte addresses, one wait state on every access.
// Notes:   Unmapped reads return zero; unmapped writes are dropped.
`timescale 1ns/100ps
module bus_regs
    import pstage_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Block state
    input  wire logic [7:0]  status_in,
    input  wire logic [2:0]  fault_in,
    output logic             enable_out
);
    typedef struct packed {
        logic        done;
        logic [31:0] rdata;
        logic [31:0] ctrl;
    } regs_state_t;

    regs_state_t st_reg;
    regs_state_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.done  = 1'b0;
        // The first cycle of a request decodes; the second releases waitrequest.
        if ((avs_read_in || avs_write_in) && !st_reg.done) begin
            st_next.done  = 1'b1;
            st_next.rdata = 32'h0000_0000;
            if (avs_read_in) begin
                unique case (avs_address_in)
                    CTRL_OFS:   st_next.rdata = st_reg.ctrl;
                    STATUS_OFS: st_next.rdata = {24'h00_0000, status_in};
                    FAULT_OFS:  st_next.rdata = {29'h0000_0000, fault_in};
                    IDENT_OFS:  st_next.rdata = IDENT_VAL;
                    default:    st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (avs_write_in && st_reg.done && avs_address_in == CTRL_OFS
                && avs_byteenable_in[0]) begin
            st_next.ctrl[CTRL_ENABLE_BIT] = avs_writedata_in[CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '{done: 1'b0, rdata: 32'h0000_0000, ctrl: CTRL_RESET_VAL};
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_out    = st_reg.rdata;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st_reg.done;
    assign enable_out          = st_reg.ctrl[CTRL_ENABLE_BIT];
endmodule : bus_regs

// File: logic/pin_sync.sv
// Purpose: Three-flop synchroniser with a settled-change qualifier.
// Assumes: Input is asynchronous to mclk_in.
// Notes:   The output only moves when flops two and three agree.
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock, reset and enable
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.q;
endmodule : pin_sync

// File: logic/power_stage_fault_protect.sv
// Purpose: Gate control, fault latching and sense-output control for a half-bridge stage.
// Assumes: Comparators for current, temperature, zero crossing and short arrive as pins.
// Notes:   Tri-level pins arrive pre-decoded as a high and a mid flag each.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps

module power_stage_fault_protect
    import pstage_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = CS_WAKE_CYC
) (
    // Clock, reset and enable
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // Controller inputs, tri-level decoded
    input  wire logic        pwm_high_in,
    input  wire logic        pwm_mid_in,
    input  wire logic        mode_high_in,
    input  wire logic        mode_mid_in,
    // Analog comparator inputs
    input  wire logic        hs_overcurrent_in,
    input  wire logic        ls_negative_limit_in,
    input  wire logic        zero_current_in,
    input  wire logic        over_temp_in,
    input  wire logic        short_to_power_ground_in,
    input  wire logic        supply_good_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Stage outputs
    output logic             high_side_switch_out,
    output logic             low_side_switch_out,
    output logic             temp_fault_output_fault_out,
    output logic             temp_fault_output_temp_en_out,
    output logic             cs_enable_out,
    output logic             cs_valid_out
);
    localparam int unsigned CNT_W = 16;

    typedef struct packed {
        stage_state_t       state;
        logic [2:0]         fault;
        logic [2:0]         oc_count;
        logic               pwm_prev;
        logic               oc_seen;
        logic [CNT_W-1:0]   tri_cnt;
        logic [CNT_W-1:0]   mode_cnt;
        logic [CNT_W-1:0]   neg_cnt;
        logic [CNT_W-1:0]   wake_cnt;
        logic               enable_prev;
        logic               hs;
        logic               ls;
        logic               flt;
        logic               temp_en;
        logic               cs_en;
        logic               cs_ok;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;

    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic        enable;
    logic [9:0]  pins;
    logic        pwm_h, pwm_m, mode_h, mode_m, hs_oc, ls_neg, zc, ot, shrt, vgood;

    // Saturating counter step used by the mode, tri-level and wake timers.
    function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
        count_up = (c == {CNT_W{1'b1}}) ? c : c + 16'h0001;
    endfunction : count_up

    pin_sync #(.WIDTH(10)) u_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .async_in ({pwm_high_in, pwm_mid_in, mode_high_in, mode_mid_in, hs_overcurrent_in,
                    ls_negative_limit_in, zero_current_in, over_temp_in,
                    short_to_power_ground_in, supply_good_in}),
        .sync_out (pins)
    );
    assign {pwm_h, pwm_m, mode_h, mode_m, hs_oc, ls_neg, zc, ot, shrt, vgood} = pins;

    bus_regs u_regs (
        .mclk_in             (mclk_in),
        .rst_n_in            (rst_n),
        .ce_in               (ce_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .status_in           ({st_reg.cs_ok, st_reg.cs_en, st_reg.flt, st_reg.ls,
                               st_reg.hs, st_reg.state}),
        .fault_in            (st_reg.fault),
        .enable_out          (enable)
    );

    // The reset synchroniser runs outside ce so release never stalls.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    always_comb begin
        logic cycle_start;
        logic release_latch;
        logic mode_standby;
        logic neg_active;
        logic tri_active;
        logic diode_ls;
        st_next          = st_reg;
        cycle_start      = pwm_h && !st_reg.pwm_prev;
        release_latch    = !vgood || (enable != st_reg.enable_prev);
        st_next.pwm_prev    = pwm_h;
        st_next.enable_prev = enable;

        st_next.mode_cnt = mode_m ? count_up(st_reg.mode_cnt) : 16'h0000;
        mode_standby     = (st_reg.mode_cnt >= 16'(STANDBY_CYC));
        st_next.tri_cnt  = pwm_m ? count_up(st_reg.tri_cnt) : 16'h0000;
        tri_active       = (st_reg.tri_cnt >= 16'(TRI_WINDOW_CYC));

        if (ls_neg) begin
            st_next.neg_cnt = 16'(NEG_LIMIT_CYC);
        end else if (st_reg.neg_cnt != 16'h0000) begin
            st_next.neg_cnt = st_reg.neg_cnt - 16'h0001;
        end
        neg_active = ls_neg || (st_reg.neg_cnt != 16'h0000);

        if (hs_oc && st_reg.hs) begin
            st_next.oc_seen = 1'b1;
        end
        if (cycle_start) begin
            st_next.oc_seen  = 1'b0;
            st_next.oc_count = st_reg.oc_seen ? st_reg.oc_count + 3'd1 : 3'd0;
        end
        if (st_next.oc_count >= 3'(OC_TRIP_COUNT)) begin
            st_next.fault[FLT_OC_BIT] = 1'b1;
        end
        if (ot) begin
            st_next.fault[FLT_OT_BIT] = 1'b1;
        end
        if (shrt) begin
            st_next.fault[FLT_SHORT_BIT] = 1'b1;
        end
        // negative limit never reaches the fault bits above.

        // Diode emulation: low side conducts until zero current.
        diode_ls = !zc && !neg_active;

        unique case (st_reg.state)
            ST_RUN: begin
                if (mode_standby) begin
                    st_next.state = ST_STANDBY;
                end else if (st_next.fault != 3'b000) begin
                    st_next.state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (zc) begin
                    st_next.state = ST_OFF;
                end
            end
            ST_OFF: begin
                st_next.state = ST_OFF;
            end
            ST_STANDBY: begin
                if (!mode_m) begin
                    st_next.state = (st_reg.fault != 3'b000) ? ST_OFF : ST_RUN;
                end
            end
            default: st_next.state = ST_OFF;
        endcase
        if (mode_standby) begin
            st_next.state = ST_STANDBY;
        end

        if (release_latch) begin
            st_next.fault    = 3'b000;
            st_next.oc_count = 3'd0;
            st_next.oc_seen  = 1'b0;
            if (st_reg.state != ST_STANDBY) begin
                st_next.state = ST_RUN;
            end
        end

        st_next.hs = 1'b0;
        st_next.ls = 1'b0;
        unique case (st_next.state)
            ST_RUN: begin
                if (tri_active || !mode_h) begin
                    st_next.ls = !pwm_h && diode_ls;
                    st_next.hs = pwm_h && !tri_active;
                end else begin
                    st_next.hs = pwm_h;
                    st_next.ls = !pwm_h && !neg_active;
                end
            end
            ST_DRAIN: st_next.ls = diode_ls;
            default: begin
                st_next.hs = 1'b0;
                st_next.ls = 1'b0;
            end
        endcase

        st_next.flt = (st_next.fault != 3'b000);
        st_next.cs_en = (st_next.state != ST_STANDBY);
        st_next.wake_cnt = st_next.cs_en ? count_up(st_reg.wake_cnt) : 16'h0000;
        st_next.cs_ok    = st_next.cs_en && (st_reg.wake_cnt >= 16'(WAKE_CYCLES));
        st_next.temp_en = vgood && st_next.cs_en && !st_next.flt;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.state       <= ST_RUN;
            st_reg.fault       <= 3'b000;
            st_reg.oc_count    <= 3'd0;
            st_reg.pwm_prev    <= 1'b0;
            st_reg.oc_seen     <= 1'b0;
            st_reg.tri_cnt     <= 16'h0000;
            st_reg.mode_cnt    <= 16'h0000;
            st_reg.neg_cnt     <= 16'h0000;
            st_reg.wake_cnt    <= 16'h0000;
            st_reg.enable_prev <= 1'b1;
            st_reg.hs          <= 1'b0;
            st_reg.ls          <= 1'b0;
            st_reg.flt         <= 1'b0;
            st_reg.temp_en     <= 1'b0;
            st_reg.cs_en       <= 1'b0;
            st_reg.cs_ok       <= 1'b0;
        end else if (ce_in) begin
            st_reg.state       <= st_next.state;
            st_reg.fault       <= st_next.fault;
            st_reg.oc_count    <= st_next.oc_count;
            st_reg.pwm_prev    <= st_next.pwm_prev;
            st_reg.oc_seen     <= st_next.oc_seen;
            st_reg.tri_cnt     <= st_next.tri_cnt;
            st_reg.mode_cnt    <= st_next.mode_cnt;
            st_reg.neg_cnt     <= st_next.neg_cnt;
            st_reg.wake_cnt    <= st_next.wake_cnt;
            st_reg.enable_prev <= st_next.enable_prev;
            st_reg.hs          <= st_next.hs;
            st_reg.ls          <= st_next.ls;
            st_reg.flt         <= st_next.flt;
            st_reg.temp_en     <= st_next.temp_en;
            st_reg.cs_en       <= st_next.cs_en;
            st_reg.cs_ok       <= st_next.cs_ok;
        end
    end

    assign high_side_switch_out          = st_reg.hs;
    assign low_side_switch_out           = st_reg.ls;
    assign temp_fault_output_fault_out   = st_reg.flt;
    assign temp_fault_output_temp_en_out = st_reg.temp_en;
    assign cs_enable_out                 = st_reg.cs_en;
    assign cs_valid_out                  = st_reg.cs_ok;
endmodule : power_stage_fault_protect

// File: test/power_stage_fault_protect_assertions.sv
// Purpose: Concurrent checks on the stage outputs of the protection block.
// Assumes: Pins pass a three-flop sync and one register before they act.
// Notes:   Windows allow for that delay; counters stand in for long holds.
`timescale 1ns/100ps
module stage_checker
    import pstage_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = CS_WAKE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Pins
    input wire logic pwm_mid_in,
    input wire logic mode_mid_in,
    input wire logic ls_negative_limit_in,
    input wire logic zero_current_in,
    input wire logic over_temp_in,
    input wire logic short_to_power_ground_in,
    input wire logic supply_good_in,
    // Stage outputs
    input wire logic high_side_switch_out,
    input wire logic low_side_switch_out,
    input wire logic temp_fault_output_fault_out,
    input wire logic temp_fault_output_temp_en_out,
    input wire logic cs_enable_out,
    input wire logic cs_valid_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0]  lvl_cnt_reg;
    logic        lvl_last_reg;
    logic [15:0] en_cnt_reg;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lvl_cnt_reg  <= 8'h00;
            lvl_last_reg <= 1'b0;
            en_cnt_reg   <= 16'h0000;
        end else begin
            lvl_last_reg <= mode_mid_in;
            lvl_cnt_reg  <= (mode_mid_in != lvl_last_reg) ? 8'h00 :
                            (lvl_cnt_reg == 8'hFF) ? lvl_cnt_reg : lvl_cnt_reg + 8'h01;
            en_cnt_reg   <= !cs_enable_out ? 16'h0000 :
                            (en_cnt_reg == 16'hFFFF) ? en_cnt_reg : en_cnt_reg + 16'h0001;
        end
    end
    sequence s_zero_held; zero_current_in [*6]; endsequence
    sequence s_neg_hit;
        ($rose(ls_negative_limit_in) && low_side_switch_out && !temp_fault_output_fault_out)
        ##1 ls_negative_limit_in;
    endsequence
    property p_fault_hs; temp_fault_output_fault_out |-> !high_side_switch_out; endproperty
    a_fault_hs: assert property (p_fault_hs) else $error("high side on with fault");
    property p_trip; ((over_temp_in || short_to_power_ground_in) && supply_good_in
        && !mode_mid_in) [*8] |-> temp_fault_output_fault_out && !high_side_switch_out;
    endproperty
    a_trip: assert property (p_trip) else $error("fault not latched");
    property p_drain; (temp_fault_output_fault_out throughout s_zero_held)
        |-> !low_side_switch_out; endproperty
    a_drain: assert property (p_drain) else $error("low side on at zero current");
    property p_stay; (temp_fault_output_fault_out && !low_side_switch_out) [*3]
        |=> !low_side_switch_out || !temp_fault_output_fault_out; endproperty
    a_stay: assert property (p_stay) else $error("low side back on while latched");
    property p_neg; s_neg_hit |-> ##[1:6] !low_side_switch_out; endproperty
    a_neg: assert property (p_neg) else $error("low side not cut");
    property p_rel; (!supply_good_in && !over_temp_in && !short_to_power_ground_in) [*6]
        |=> !temp_fault_output_fault_out; endproperty
    a_rel: assert property (p_rel) else $error("latch kept over supply loss");
    property p_temp; (!supply_good_in) [*6] |-> !temp_fault_output_temp_en_out; endproperty
    a_temp: assert property (p_temp) else $error("temp shown below lockout");
    property p_stby; lvl_cnt_reg == 8'd50 && mode_mid_in |-> !cs_enable_out
        && !temp_fault_output_temp_en_out && !high_side_switch_out; endproperty
    a_stby: assert property (p_stby) else $error("standby not entered");
    property p_wake; cs_valid_out |-> en_cnt_reg >= 16'(WAKE_CYCLES); endproperty
    a_wake: assert property (p_wake) else $error("sense valid too early");
    property p_tri; pwm_mid_in [*7] |-> !high_side_switch_out; endproperty
    a_tri: assert property (p_tri) else $error("high side on in tri window");
endmodule : stage_checker

bind power_stage_fault_protect stage_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pwm_mid_in(pwm_mid_in),
    .mode_mid_in(mode_mid_in), .ls_negative_limit_in(ls_negative_limit_in),
    .zero_current_in(zero_current_in), .over_temp_in(over_temp_in),
    .short_to_power_ground_in(short_to_power_ground_in), .supply_good_in(supply_good_in),
    .high_side_switch_out(high_side_switch_out), .low_side_switch_out(low_side_switch_out),
    .temp_fault_output_fault_out(temp_fault_output_fault_out),
    .temp_fault_output_temp_en_out(temp_fault_output_temp_en_out),
    .cs_enable_out(cs_enable_out), .cs_valid_out(cs_valid_out)
);

// File: test/pwm_ctrl_model.sv
// Purpose: Behavioural multiphase controller driving PWM and mode-select pins.
// Assumes: Pins arrive at the stage already decoded into level flags.
// Notes:   PWM free-runs at PERIOD clocks, high for the first half.
`timescale 1ns/100ps
module pwm_ctrl_model
    import pstage_pkg::*;
#(
    parameter int unsigned PERIOD = 30
) (
    // Clock and reset
    input  wire logic    mclk_in,
    input  wire logic    rst_n_in,
    // Commands
    input  wire logic    run_in,
    input  wire logic    tri_in,
    input  wire level_t  mode_in,
    // Pins
    output logic         pwm_high_out,
    output logic         pwm_mid_out,
    output logic         mode_high_out,
    output logic         mode_mid_out
);
    logic [7:0] ph_reg;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_reg <= 8'h00;
        end else begin
            ph_reg <= (ph_reg == 8'(PERIOD - 1)) ? 8'h00 : ph_reg + 8'h01;
        end
    end
    assign pwm_mid_out   = tri_in;
    assign pwm_high_out  = run_in && !tri_in && (ph_reg < 8'(PERIOD / 2));
    assign mode_high_out = (mode_in == LVL_HIGH);
    assign mode_mid_out  = (mode_in == LVL_MID);
endmodule : pwm_ctrl_model

// File: test/tb_top.sv
// Purpose: Self-checking bench for the power stage protection block.
// Assumes: Controller model drives PWM and mode; comparators driven here.
// Notes:   Wake time shortened to WAKE cycles to keep the run short.
`timescale 1ns/100ps
module tb_top
    import pstage_pkg::*;
;
    localparam int unsigned WAKE = 8;
    logic        clk, rst_n = 1'b0, run = 1'b0, tri_cmd = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        oc = 1'b0, neg = 1'b0, zc = 1'b0, ot = 1'b0, sh = 1'b0, sup = 1'b1;
    level_t      mode = LVL_HIGH;
    logic        wreq, hs, ls, flt, ten, cse, csv, pwm_h, pwm_m, mode_h, mode_m;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, rbuf;
    int          miscompares = 0, n_checks = 0, cyc = 0;

    power_stage_fault_protect #(.WAKE_CYCLES(WAKE)) dut (
        .mclk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .pwm_high_in(pwm_h),
        .pwm_mid_in(pwm_m), .mode_high_in(mode_h), .mode_mid_in(mode_m),
        .hs_overcurrent_in(oc), .ls_negative_limit_in(neg), .zero_current_in(zc),
        .over_temp_in(ot), .short_to_power_ground_in(sh), .supply_good_in(sup),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .high_side_switch_out(hs), .low_side_switch_out(ls), .temp_fault_output_fault_out(flt),
        .temp_fault_output_temp_en_out(ten), .cs_enable_out(cse), .cs_valid_out(csv)
    );
    pwm_ctrl_model #(.PERIOD(30)) ctl (
        .mclk_in(clk), .rst_n_in(rst_n), .run_in(run), .tri_in(tri_cmd), .mode_in(mode),
        .pwm_high_out(pwm_h), .pwm_mid_out(pwm_m), .mode_high_out(mode_h), .mode_mid_out(mode_m)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
    endtask : settle

    // The request stays up until waitrequest is seen low, then drops for one cycle.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        rbuf = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rbuf, e);
    endtask : rd_chk

    task automatic toggle_en();
        bus(1'b1, CTRL_OFS, 32'h0000_0000);
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
    endtask : toggle_en

    task automatic wait_gate(input logic hi, input logic v, input int lim);
        int n;
        n = 0;
        while ((hi ? hs : ls) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(hi ? hs : ls, v);
    endtask : wait_gate

    // Over-current lands mid high phase so it overlaps the synced high-side gate.
    task automatic oc_burst(input int k);
        repeat (k) begin
            @(posedge pwm_h);
            settle(3);
            oc <= 1'b1;
            settle(4);
            oc <= 1'b0;
        end
    endtask : oc_burst

    initial begin
        settle(16);
        rst_n <= 1'b1;
        settle(4);
        rd_chk(CTRL_OFS, CTRL_RESET_VAL);
        rd_chk(IDENT_OFS, IDENT_VAL);
        rd_chk(4'h1, 32'h0000_0000);
        $display("test regs done");
        run <= 1'b1;
        settle(40);
        oc_burst(3);
        settle(70);
        oc_burst(3);
        settle(70);
        rd_chk(FAULT_OFS, 32'h0000_0000);
        oc_burst(4);
        settle(40);
        chk({flt, ls}, 2'b11);
        rd_chk(FAULT_OFS, 32'h0000_0001 << FLT_OC_BIT);
        zc <= 1'b1;
        settle(70);
        chk({hs, ls, flt}, 3'b001);
        $display("test overcurrent done");
        toggle_en();
        zc <= 1'b0;
        settle(20);
        chk(flt, 1'b0);
        wait_gate(1'b1, 1'b1, 200);
        wait_gate(1'b0, 1'b1, 200);
        neg <= 1'b1;
        settle(2);
        neg <= 1'b0;
        wait_gate(1'b0, 1'b0, 6);
        settle(20);
        chk(flt, 1'b0);
        rd_chk(FAULT_OFS, 32'h0000_0000);
        $display("test negative limit done");
        tri_cmd <= 1'b1;
        settle(8);
        chk(hs, 1'b0);
        tri_cmd <= 1'b0;
        mode <= LVL_LOW;
        settle(10);
        chk({cse, ten}, 2'b11);
        mode <= LVL_HIGH;
        $display("test modes done");
        ot <= 1'b1;
        settle(9);
        ot <= 1'b0;
        settle(10);
        chk({flt, hs}, 2'b10);
        rd_chk(FAULT_OFS, 32'h0000_0001 << FLT_OT_BIT);
        mode <= LVL_MID;
        settle(60);
        chk({cse, ten}, 2'b00);
        rd_chk(FAULT_OFS, 32'h0000_0001 << FLT_OT_BIT);
        mode <= LVL_HIGH;
        settle(8);
        chk({cse, csv}, 2'b10);
        settle(WAKE + 4);
        chk(csv, 1'b1);
        rd_chk(FAULT_OFS, 32'h0000_0001 << FLT_OT_BIT);
        sup <= 1'b0;
        settle(8);
        chk(ten, 1'b0);
        sup <= 1'b1;
        settle(10);
        rd_chk(FAULT_OFS, 32'h0000_0000);
        $display("test thermal done");
        sh <= 1'b1;
        settle(4);
        sh <= 1'b0;
        settle(10);
        chk({flt, hs}, 2'b10);
        rd_chk(FAULT_OFS, 32'h0000_0001 << FLT_SHORT_BIT);
        toggle_en();
        settle(10);
        chk(flt, 1'b0);
        $display("test short done");
        tally_and_finish();
    end
endmodule : tb_top
